/* src/vdh_params.svh */
`ifndef VDH_PARAMS_SVH
`define VDH_PARAMS_SVH

`define VDH_CLK_MHZ     40
`define VDH_ADDR_W      9
`define VDH_DATA_W      4
`define VDH_CEIL_CYC(ns) ((((ns) * `VDH_CLK_MHZ) + 999) / 1000)

`define VDH_T_RAH_NS    15
`define VDH_T_CAS_NS    25
`define VDH_T_RAS_NS    100
`define VDH_T_RP_NS     70
`define VDH_T_CP_NS     10
`define VDH_T_OEA_NS    25
`define VDH_T_OED_NS    20
`define VDH_T_WP_NS     20
`define VDH_T_CSR_NS    10
`define VDH_T_REF_MS    8
`define VDH_REF_ROWS    512
`define VDH_MAX_PEND    8

`define VDH_RAH_CYC     `VDH_CEIL_CYC(`VDH_T_RAH_NS)
`define VDH_CAS_CYC     `VDH_CEIL_CYC(`VDH_T_CAS_NS)
`define VDH_RAS_CYC     `VDH_CEIL_CYC(`VDH_T_RAS_NS)
`define VDH_RP_CYC      `VDH_CEIL_CYC(`VDH_T_RP_NS)
`define VDH_CP_CYC      `VDH_CEIL_CYC(`VDH_T_CP_NS)
`define VDH_OEA_CYC     `VDH_CEIL_CYC(`VDH_T_OEA_NS)
`define VDH_OED_CYC     `VDH_CEIL_CYC(`VDH_T_OED_NS)
`define VDH_WP_CYC      `VDH_CEIL_CYC(`VDH_T_WP_NS)
`define VDH_CSR_CYC     `VDH_CEIL_CYC(`VDH_T_CSR_NS)
`define VDH_REF_INT_CYC \
  ((`VDH_T_REF_MS * 1000000 * `VDH_CLK_MHZ / 1000) / `VDH_REF_ROWS)

`endif

/* src/vdh_pkg.sv */
package vdh_pkg;

  typedef enum logic [3:0] {
    VDH_CMD_READ       = 4'h0,
    VDH_CMD_WRITE      = 4'h1,
    VDH_CMD_LATE_WRITE = 4'h2,
    VDH_CMD_RMW        = 4'h3,
    VDH_CMD_RAS_REF    = 4'h4,
    VDH_CMD_CBR_REF    = 4'h5,
    VDH_CMD_HIDDEN     = 4'h6,
    VDH_CMD_XFER_RD    = 4'h7,
    VDH_CMD_XFER_WR    = 4'h8,
    VDH_CMD_XFER_PSEUDO = 4'h9
  } vdh_cmd_t;

  typedef enum logic [11:0] {
    ST_IDLE   = 12'h001,
    ST_SETUP  = 12'h002,
    ST_ROW    = 12'h004,
    ST_COL    = 12'h008,
    ST_ACC    = 12'h010,
    ST_RMWSET = 12'h020,
    ST_WLATE  = 12'h040,
    ST_HOLD   = 12'h080,
    ST_CPRE   = 12'h100,
    ST_HIDUP  = 12'h200,
    ST_PRE    = 12'h400,
    ST_CSR    = 12'h800
  } vdh_state_t;

endpackage : vdh_pkg

/* src/vdh_ref_if.sv */
`timescale 1ns/100ps

interface vdh_ref_if;
  logic req;
  logic ack;
  modport sched (output req, input ack);
  modport ctrl  (input req, output ack);
endinterface : vdh_ref_if

/* src/vdh_refresh_sched.sv */
`timescale 1ns/100ps
`include "vdh_params.svh"

module vdh_refresh_sched
  import vdh_pkg::*;
#(
  parameter int INTERVAL = `VDH_REF_INT_CYC,
  parameter int MAX_PEND = `VDH_MAX_PEND
)
(
  input  wire logic      sys_clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      ce_in,
  vdh_ref_if.sched       rif
);

  logic [15:0] tick_cnt_r;
  logic [3:0]  pend_r;
  logic        tick;

  assign tick    = (tick_cnt_r == 16'(INTERVAL - 1));
  assign rif.req = (pend_r != 4'h0);

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tick_cnt_r <= 16'h0000;
    else if (ce_in)
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end

  // pending refresh count
  // A slot that falls in the cycle a refresh is granted is kept.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pend_r <= 4'h0;
    else if (ce_in)
    begin
      if (tick && !rif.ack && pend_r != 4'(MAX_PEND))
        pend_r <= pend_r + 4'h1;
      else if (!tick && rif.ack)
        pend_r <= pend_r - 4'h1;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  pend_count_up_a: assert property (ce_in && tick && !rif.ack && pend_r < 4'(MAX_PEND)
    |=> pend_r == $past(pend_r) + 4'h1)
    else $error("refresh slot was not counted");

endmodule : vdh_refresh_sched

/* src/vdh_host.sv */
`timescale 1ns/100ps
`include "vdh_params.svh"

module vdh_host
  import vdh_pkg::*;
#(
  parameter int ADDR_W  = `VDH_ADDR_W,
  parameter int DATA_W  = `VDH_DATA_W,
  parameter int REF_INT = `VDH_REF_INT_CYC,
  parameter int WAIT_W  = 4
)
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire logic              cmd_valid_in,
  input  wire logic [3:0]        cmd_type_in,
  input  wire logic [ADDR_W-1:0] cmd_row_in,
  input  wire logic [ADDR_W-1:0] cmd_col_in,
  input  wire logic [DATA_W-1:0] cmd_data_in,
  input  wire logic [DATA_W-1:0] cmd_mask_in,
  input  wire logic              cmd_mask_en_in,
  input  wire logic              cmd_page_in,
  output logic                   cmd_ready_out,
  output logic [DATA_W-1:0]      rd_data_out,
  output logic                   rd_valid_out,
  output logic                   row_strobe_n_out,
  output logic                   column_strobe_n_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   transfer_output_enable_n_out,
  output logic                   mask_write_enable_n_out,
  output logic                   serial_enable_n_out,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_out
);

  localparam logic [3:0] RAS_AGE_MIN = 4'(`VDH_RAS_CYC - 1);

  vdh_ref_if rif ();

  vdh_state_t          state_r, state_nxt;
  logic [WAIT_W-1:0]   wait_r, wait_nxt;
  logic [3:0]          age_r;
  logic [3:0]          hi_cnt_r;
  vdh_cmd_t            cmd_r, cmd_in;
  logic [ADDR_W-1:0]   row_r, col_r;
  logic [DATA_W-1:0]   wdat_r;
  logic                hid_done_r;
  logic                ras_n_r, ras_n_nxt, cas_n_r, cas_n_nxt;
  logic                oe_n_r, oe_n_nxt, we_n_r, we_n_nxt, se_n_r, se_n_nxt;
  logic                dq_oe_r, dq_oe_nxt, ready_r, ready_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic [DATA_W-1:0]   dq_r, dq_nxt;
  logic                take, in_wr, in_xfer, cur_xfer, page_ok;

  function automatic logic [WAIT_W-1:0] cyc(input int n);
    return WAIT_W'(n - 1);
  endfunction : cyc

  function automatic logic pageable(input vdh_cmd_t c);
    return c == VDH_CMD_READ || c == VDH_CMD_WRITE || c == VDH_CMD_LATE_WRITE
        || c == VDH_CMD_RMW;
  endfunction : pageable

  vdh_refresh_sched #(.INTERVAL(REF_INT)) u_sched (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .ce_in      (ce_in),
    .rif        (rif)
  );

  assign cmd_in   = vdh_cmd_t'(cmd_type_in);
  assign take     = cmd_valid_in && ready_r;
  assign in_wr    = cmd_in == VDH_CMD_WRITE || cmd_in == VDH_CMD_LATE_WRITE
                 || cmd_in == VDH_CMD_RMW;
  assign in_xfer  = cmd_in == VDH_CMD_XFER_RD || cmd_in == VDH_CMD_XFER_WR
                 || cmd_in == VDH_CMD_XFER_PSEUDO;
  assign cur_xfer = cmd_r == VDH_CMD_XFER_RD || cmd_r == VDH_CMD_XFER_WR
                 || cmd_r == VDH_CMD_XFER_PSEUDO;
  assign page_ok  = cmd_valid_in && cmd_page_in && cmd_row_in == row_r && pageable(cmd_in)
                 && pageable(cmd_r) && !rif.req;

  always_comb
  begin
    state_nxt = state_r;
    wait_nxt  = (wait_r == '0) ? wait_r : wait_r - 1'b1;
    ras_n_nxt = ras_n_r;
    cas_n_nxt = cas_n_r;
    oe_n_nxt  = oe_n_r;
    we_n_nxt  = we_n_r;
    se_n_nxt  = se_n_r;
    dq_oe_nxt = dq_oe_r;
    addr_nxt  = addr_r;
    dq_nxt    = dq_r;
    rif.ack   = 1'b0;
    case (state_r)
      ST_IDLE:
        if (take && cmd_in == VDH_CMD_CBR_REF || !take && rif.req)
        begin
          rif.ack   = !take;
          cas_n_nxt = 1'b0;
          state_nxt = ST_CSR;
          wait_nxt  = cyc(`VDH_CSR_CYC);
        end
        else if (take)
        begin
          addr_nxt  = cmd_row_in;
          // transfer type picked by levels at row strobe fall
          oe_n_nxt  = !in_xfer;
          // mask latched by write enable low at row strobe fall
          we_n_nxt  = !(cmd_mask_en_in && in_wr || cmd_in == VDH_CMD_XFER_WR
                        || cmd_in == VDH_CMD_XFER_PSEUDO);
          se_n_nxt  = cmd_in != VDH_CMD_XFER_WR;
          dq_nxt    = cmd_mask_in;
          dq_oe_nxt = cmd_mask_en_in && in_wr;
          state_nxt = ST_SETUP;
        end
      ST_SETUP:
      begin
        // row strobe falls with column strobe high
        ras_n_nxt = 1'b0;
        state_nxt = ST_ROW;
        wait_nxt  = cyc(`VDH_RAH_CYC);
      end
      ST_CSR:
        if (wait_r == '0)
        begin
          ras_n_nxt = 1'b0;
          state_nxt = ST_HOLD;
        end
      ST_ROW, ST_CPRE:
        if (wait_r == '0)
        begin
          // row-only refresh never lowers column strobe
          if (cmd_r == VDH_CMD_RAS_REF)
            state_nxt = ST_HOLD;
          else
          begin
            // column address follows row address on shared pins
            addr_nxt  = col_r;
            cas_n_nxt = 1'b0;
            dq_nxt    = wdat_r;
            if (cmd_r == VDH_CMD_WRITE)
            begin
              // early write lowers write enable by column strobe
              we_n_nxt  = 1'b0;
              dq_oe_nxt = 1'b1;
            end
            else if (!cur_xfer)
            begin
              // mask phase ends on the edge where column strobe falls
              we_n_nxt  = 1'b1;
              dq_oe_nxt = 1'b0;
            end
            state_nxt = ST_COL;
            wait_nxt  = cyc(`VDH_CAS_CYC);
          end
        end
      ST_COL:
        if (wait_r == '0)
          case (cmd_r)
            VDH_CMD_READ, VDH_CMD_HIDDEN, VDH_CMD_RMW:
            begin
              // output enable low for the access time
              oe_n_nxt  = 1'b0;
              state_nxt = ST_ACC;
              wait_nxt  = cyc(`VDH_OEA_CYC);
            end
            VDH_CMD_LATE_WRITE:
            begin
              // write enable falls after column strobe
              we_n_nxt  = 1'b0;
              dq_oe_nxt = 1'b1;
              state_nxt = ST_WLATE;
              wait_nxt  = cyc(`VDH_WP_CYC);
            end
            VDH_CMD_XFER_RD, VDH_CMD_XFER_WR, VDH_CMD_XFER_PSEUDO:
            begin
              // output enable rise completes the transfer
              oe_n_nxt  = 1'b1;
              state_nxt = ST_HOLD;
            end
            default:
            begin
              we_n_nxt  = 1'b1;
              dq_oe_nxt = 1'b0;
              state_nxt = ST_HOLD;
            end
          endcase
      ST_ACC:
        if (wait_r == '0)
        begin
          if (cmd_r == VDH_CMD_RMW)
          begin
            // release output enable before driving write data
            oe_n_nxt  = 1'b1;
            state_nxt = ST_RMWSET;
            wait_nxt  = cyc(`VDH_OED_CYC);
          end
          else
            state_nxt = ST_HOLD;
        end
      ST_RMWSET:
        if (wait_r == '0)
        begin
          we_n_nxt  = 1'b0;
          dq_oe_nxt = 1'b1;
          state_nxt = ST_WLATE;
          wait_nxt  = cyc(`VDH_WP_CYC);
        end
      ST_WLATE:
        if (wait_r == '0)
        begin
          we_n_nxt  = 1'b1;
          dq_oe_nxt = 1'b0;
          state_nxt = ST_HOLD;
        end
      ST_HOLD:
        if (take)
        begin
          // next column in the open row
          cas_n_nxt = 1'b1;
          oe_n_nxt  = 1'b1;
          state_nxt = ST_CPRE;
          wait_nxt  = cyc(`VDH_CP_CYC);
        end
        // row strobe held for its minimum low width
        else if (age_r >= RAS_AGE_MIN)
        begin
          ras_n_nxt = 1'b1;
          wait_nxt  = cyc(`VDH_RP_CYC);
          if (cmd_r == VDH_CMD_HIDDEN && !hid_done_r)
            // column strobe and output enable stay low
            state_nxt = ST_HIDUP;
          else
          begin
            cas_n_nxt = 1'b1;
            oe_n_nxt  = 1'b1;
            we_n_nxt  = 1'b1;
            se_n_nxt  = 1'b1;
            dq_oe_nxt = 1'b0;
            state_nxt = ST_PRE;
          end
        end
      ST_HIDUP:
        if (wait_r == '0)
        begin
          ras_n_nxt = 1'b0;
          state_nxt = ST_HOLD;
        end
      ST_PRE:
        if (wait_r == '0)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
    ready_nxt = (state_nxt == ST_IDLE && !rif.req)
             || (state_nxt == ST_HOLD && page_ok);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_IDLE;
      wait_r  <= '0;
      ready_r <= 1'b0;
    end
    else if (ce_in)
    begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      ready_r <= ready_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ras_n_r <= 1'b1;
      cas_n_r <= 1'b1;
      oe_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
      se_n_r  <= 1'b1;
      dq_oe_r <= 1'b0;
      addr_r  <= '0;
      dq_r    <= '0;
    end
    else if (ce_in)
    begin
      ras_n_r <= ras_n_nxt;
      cas_n_r <= cas_n_nxt;
      oe_n_r  <= oe_n_nxt;
      we_n_r  <= we_n_nxt;
      se_n_r  <= se_n_nxt;
      dq_oe_r <= dq_oe_nxt;
      addr_r  <= addr_nxt;
      dq_r    <= dq_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cmd_r      <= VDH_CMD_READ;
      row_r      <= '0;
      col_r      <= '0;
      wdat_r     <= '0;
      hid_done_r <= 1'b0;
    end
    else if (ce_in)
    begin
      if (take)
      begin
        cmd_r  <= cmd_in;
        row_r  <= cmd_row_in;
        col_r  <= cmd_col_in;
        wdat_r <= cmd_data_in;
      end
      else if (state_r == ST_IDLE && rif.req)
        cmd_r <= VDH_CMD_CBR_REF;
      if (state_r == ST_IDLE)
        hid_done_r <= 1'b0;
      else if (state_r == ST_HIDUP)
        hid_done_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      age_r    <= 4'h0;
      hi_cnt_r <= 4'hF;
    end
    else if (ce_in)
    begin
      age_r    <= ras_n_r ? 4'h0 : (age_r == 4'hF ? age_r : age_r + 4'h1);
      hi_cnt_r <= !ras_n_r ? 4'h0 : (hi_cnt_r == 4'hF ? hi_cnt_r : hi_cnt_r + 4'h1);
    end
  end

  // read data sampled after the access time
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end
    else if (ce_in)
    begin
      rd_valid_out <= state_r == ST_ACC && wait_r == '0;
      if (state_r == ST_ACC && wait_r == '0)
        rd_data_out <= data_in;
    end
  end

  assign cmd_ready_out                = ready_r;
  assign row_strobe_n_out             = ras_n_r;
  assign column_strobe_n_out          = cas_n_r;
  assign addr_out                     = addr_r;
  assign transfer_output_enable_n_out = oe_n_r;
  assign mask_write_enable_n_out      = we_n_r;
  assign serial_enable_n_out          = se_n_r;
  assign data_out                     = dq_r;
  assign data_oe_out                  = dq_oe_r;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rmw_read_done;
    (cmd_r == VDH_CMD_RMW) && !cas_n_r ##1 $rose(oe_n_r);
  endsequence

  row_first_a: assert property (state_r == ST_ROW && $fell(ras_n_r)
    |-> cas_n_r && addr_r == row_r)
    else $error("row strobe fell without row address or with column strobe low");
  precharge_min_a: assert property ($fell(ras_n_r) |-> hi_cnt_r >= 4'(`VDH_RP_CYC))
    else $error("row precharge too short");
  ras_width_a: assert property ($rose(ras_n_r) |-> $past(age_r) >= RAS_AGE_MIN)
    else $error("row strobe low width too short");
  cas_width_a: assert property ($fell(cas_n_r) |=> !cas_n_r && !ras_n_r)
    else $error("column strobe low width too short");
  read_we_high_a: assert property (cmd_r == VDH_CMD_READ && !cas_n_r |-> we_n_r)
    else $error("write enable low in a read");
  no_bus_fight_a: assert property (!oe_n_r |-> !dq_oe_r)
    else $error("data driven while output enable low");
  write_data_a: assert property (($fell(we_n_r) || $fell(cas_n_r)) && !we_n_r && !cas_n_r
    && !cur_xfer |-> dq_oe_r && dq_r == wdat_r)
    else $error("write data not valid at the later strobe");
  rmw_order_a: assert property (s_rmw_read_done |=> $fell(we_n_r))
    else $error("write enable did not fall after output enable rise");
  page_row_held_a: assert property (state_r == ST_CPRE && $fell(cas_n_nxt)
    |-> !ras_n_r)
    else $error("row strobe released during page cycle");
  ras_only_a: assert property (cmd_r == VDH_CMD_RAS_REF && !ras_n_r |-> cas_n_r)
    else $error("column strobe low in row-only refresh");
  hidden_hold_a: assert property (state_r == ST_HIDUP |-> !cas_n_r && !oe_n_r)
    else $error("hidden refresh dropped read data");

endmodule : vdh_host

/* verif/vdh_dev_model.sv */
`timescale 1ns/100ps
`include "vdh_params.svh"

module vdh_dev_model
(
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic [8:0]  a_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        se_n_in,
  input  wire logic [3:0]  dq_in,
  input  wire logic        hoe_in,
  output logic [3:0]       q_out,
  output logic             qoe_out,
  output logic             sout_out,
  output logic [8:0]       tap_out,
  output logic [15:0]      cbr_out,
  output logic [8:0]       ronly_out,
  output logic [7:0]       viol_out
);
  logic [3:0]  mem [0:262143];
  logic [3:0]  serial_register [0:511];
  logic [8:0]  row_r;
  logic [17:0] ad_r;
  logic [3:0]  mask_r;
  logic [1:0]  kind_r;
  logic        men_r;
  logic        xfer_r;
  logic        cbr_r;
  logic        cseen_r;
  realtime     t_rf = -1000.0;
  realtime     t_rr = -1000.0;

  initial
  begin
    {viol_out, cbr_out, tap_out, ronly_out, sout_out} = '0;
    xfer_r = 1'b0;
  end

  assign qoe_out = !cas_n_in && !oe_n_in && !xfer_r;

  task automatic wr(input logic [3:0] d);
    if (hoe_in !== 1'b1) viol_out++;
    for (int b = 0; b < 4; b++)
      if (!men_r || mask_r[b]) mem[ad_r][b] = d[b];
  endtask : wr

  always @(negedge ras_n_in)
  begin
    if ($realtime - t_rr < `VDH_T_RP_NS) viol_out++;
    t_rf = $realtime;
    cseen_r = 1'b0;
    #1;
    cbr_r = !cas_n_in;
    xfer_r = 1'b0;
    men_r = 1'b0;
    row_r = a_in;
    if (cbr_r) cbr_out++;
    else if (!oe_n_in)
    begin
      xfer_r = 1'b1;
      kind_r = we_n_in ? 2'h0 : (se_n_in ? 2'h2 : 2'h1);
    end
    else
    begin
      men_r = !we_n_in;
      mask_r = dq_in;
    end
  end

  always @(posedge ras_n_in)
  begin
    if ($realtime - t_rf < `VDH_T_RAS_NS) viol_out++;
    t_rr = $realtime;
    if (!cbr_r && !xfer_r && !cseen_r) ronly_out = row_r;
  end

  always @(negedge cas_n_in)
  begin
    #1;
    if (!ras_n_in && !cbr_r)
    begin
      cseen_r = 1'b1;
      ad_r = {row_r, a_in};
      if (xfer_r)
      begin
        // pointer starts at the tap, taken from the column address.
        tap_out = a_in;
        sout_out = (kind_r == 2'h0);
        for (int i = 0; i < 512; i++)
          if (kind_r == 2'h0) serial_register[i] = mem[{row_r, 9'(i)}];
          else if (kind_r == 2'h1) mem[{row_r, 9'(i)}] = serial_register[i];
      end
      else
      begin
        q_out = mem[ad_r];
        if (!we_n_in) wr(dq_in);
      end
    end
  end

  always @(negedge we_n_in)
  begin
    #1;
    if (!ras_n_in && !cas_n_in && cseen_r && !xfer_r) wr(dq_in);
  end
endmodule : vdh_dev_model

/* verif/test_vdh_host.sv */
`timescale 1ns/100ps

`define CHK_EQ(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_vdh_host;
  localparam int REF_INT = 200;

  typedef struct packed {
    logic [3:0] cmd;
    logic [8:0] row;
    logic [8:0] col;
    logic [3:0] data;
    logic [3:0] mask;
    logic       men;
    logic       rd;
    logic [3:0] exp;
  } vdh_tb_row_t;

  logic        sys_clk_in;
  logic        rst_n_in;
  logic        ce_in;
  logic        cmd_valid_in;
  logic [3:0]  cmd_type_in;
  logic [8:0]  cmd_row_in;
  logic [8:0]  cmd_col_in;
  logic [3:0]  cmd_data_in;
  logic [3:0]  cmd_mask_in;
  logic        cmd_mask_en_in;
  logic        cmd_page_in;
  logic        cmd_ready_out;
  logic [3:0]  rd_data_out;
  logic        rd_valid_out;
  logic        row_strobe_n_out;
  logic        column_strobe_n_out;
  logic [8:0]  addr_out;
  logic        transfer_output_enable_n_out;
  logic        mask_write_enable_n_out;
  logic        serial_enable_n_out;
  logic [3:0]  data_out;
  logic        data_oe_out;
  logic [3:0]  dev_q;
  logic        dev_oe;
  logic        ser_out;
  logic [8:0]  tap;
  logic [15:0] cbr_cnt;
  logic [8:0]  ronly_row;
  logic [7:0]  viol;
  logic [3:0]  dq_hold = 4'h0;
  logic [3:0]  got;
  logic [3:0]  rd_q [$];
  int          bad_count = 0;
  int          compares = 0;
  int          ras_falls = 0;
  int          c0;
  int          f0;
  int          n;

  // A released data line shows the inverse of its last level.
  wire  [3:0]  data_in = (data_oe_out === 1'b1) ? data_out :
                         (dev_oe === 1'b1) ? dev_q : ~dq_hold;

  vdh_tb_row_t rows [18] = '{
    '{4'h1, 9'h005, 9'h007, 4'hA, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h0, 9'h005, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'hA},
    '{4'h2, 9'h005, 9'h007, 4'h5, 4'h3, 1'b1, 1'b0, 4'h0},
    '{4'h0, 9'h005, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'h9},
    '{4'h3, 9'h005, 9'h007, 4'h6, 4'h0, 1'b0, 1'b1, 4'h9},
    '{4'h6, 9'h005, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'h6},
    '{4'h1, 9'h005, 9'h007, 4'hF, 4'h0, 1'b1, 1'b0, 4'h0},
    '{4'h0, 9'h005, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'h6},
    '{4'h1, 9'h005, 9'h007, 4'hC, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h0, 9'h005, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'hC},
    '{4'h1, 9'h005, 9'h1FF, 4'h3, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h4, 9'h009, 9'h000, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h5, 9'h000, 9'h000, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h7, 9'h005, 9'h1FF, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h9, 9'h000, 9'h002, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h8, 9'h006, 9'h004, 4'h0, 4'h0, 1'b0, 1'b0, 4'h0},
    '{4'h0, 9'h006, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'hC},
    '{4'h0, 9'h006, 9'h1FF, 4'h0, 4'h0, 1'b0, 1'b1, 4'h3}
  };

  vdh_host #(
    .REF_INT (REF_INT)
  ) i_vdh_host (
    .sys_clk_in,
    .rst_n_in,
    .ce_in,
    .cmd_valid_in,
    .cmd_type_in,
    .cmd_row_in,
    .cmd_col_in,
    .cmd_data_in,
    .cmd_mask_in,
    .cmd_mask_en_in,
    .cmd_page_in,
    .cmd_ready_out,
    .rd_data_out,
    .rd_valid_out,
    .row_strobe_n_out,
    .column_strobe_n_out,
    .addr_out,
    .transfer_output_enable_n_out,
    .mask_write_enable_n_out,
    .serial_enable_n_out,
    .data_in,
    .data_out,
    .data_oe_out
  );

  vdh_dev_model i_vdh_dev_model (
    .ras_n_in  (row_strobe_n_out),
    .cas_n_in  (column_strobe_n_out),
    .a_in      (addr_out),
    .oe_n_in   (transfer_output_enable_n_out),
    .we_n_in   (mask_write_enable_n_out),
    .se_n_in   (serial_enable_n_out),
    .dq_in     (data_in),
    .hoe_in    (data_oe_out),
    .q_out     (dev_q),
    .qoe_out   (dev_oe),
    .sout_out  (ser_out),
    .tap_out   (tap),
    .cbr_out   (cbr_cnt),
    .ronly_out (ronly_row),
    .viol_out  (viol)
  );

  initial
  begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  always @(negedge sys_clk_in)
    if (rd_valid_out === 1'b1) rd_q.push_back(rd_data_out);

  always @(negedge row_strobe_n_out)
    ras_falls++;

  always @(posedge sys_clk_in)
    if (data_oe_out === 1'b1 || dev_oe === 1'b1) dq_hold <= data_in;

  task automatic stop_test;
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic wait_idle;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 400)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    `CHK_EQ(n < 400, 1'b1)
  endtask : wait_idle

  task automatic do_cmd(input vdh_tb_row_t r, input logic page);
    @(negedge sys_clk_in);
    {cmd_type_in, cmd_row_in, cmd_col_in, cmd_data_in, cmd_mask_in, cmd_mask_en_in} = r[35:5];
    cmd_page_in = page;
    cmd_valid_in = 1'b1;
    wait_idle();
    @(negedge sys_clk_in);
    cmd_valid_in = 1'b0;
  endtask : do_cmd

  task automatic check_rd(input logic [3:0] exp);
    got = (rd_q.size() != 0) ? rd_q.pop_front() : 4'hX;
    `CHK_EQ(got, exp)
  endtask : check_rd

  initial
  begin
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    {cmd_valid_in, cmd_type_in, cmd_row_in, cmd_col_in, cmd_page_in} = '0;
    {cmd_data_in, cmd_mask_in, cmd_mask_en_in} = '0;
    repeat (10) @(negedge sys_clk_in);
    `CHK_EQ({row_strobe_n_out, column_strobe_n_out, cmd_ready_out, data_oe_out}, 4'hC)
    rst_n_in = 1'b1;
    foreach (rows[i])
    begin
      rd_q.delete();
      c0 = cbr_cnt;
      do_cmd(rows[i], 1'b0);
      wait_idle();
      if (rows[i].rd) check_rd(rows[i].exp);
      if (rows[i].cmd >= 4'h7)
        `CHK_EQ({ser_out, tap}, {rows[i].cmd == 4'h7, rows[i].col})
      if (rows[i].cmd == 4'h4)
        `CHK_EQ(ronly_row, rows[i].row)
      if (rows[i].cmd == 4'h5 || rows[i].cmd == 4'h6)
        `CHK_EQ(cbr_cnt != c0, 1'b1)
    end
    // Start the page pair just after a refresh so none can cut in.
    c0 = cbr_cnt;
    n = 0;
    while (cbr_cnt == c0 && n < 400)
    begin
      @(negedge sys_clk_in);
      n++;
    end
    `CHK_EQ(n < 400, 1'b1)
    wait_idle();
    rd_q.delete();
    f0 = ras_falls;
    do_cmd('{4'h0, 9'h005, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'h0}, 1'b1);
    do_cmd('{4'h1, 9'h005, 9'h008, 4'h3, 4'h0, 1'b0, 1'b0, 4'h0}, 1'b1);
    wait_idle();
    check_rd(4'hC);
    `CHK_EQ(ras_falls - f0, 1)
    do_cmd('{4'h0, 9'h005, 9'h008, 4'h0, 4'h0, 1'b0, 1'b1, 4'h0}, 1'b0);
    wait_idle();
    check_rd(4'h3);
    c0 = cbr_cnt;
    repeat (10 * REF_INT) @(negedge sys_clk_in);
    `CHK_EQ((cbr_cnt - c0) inside {[9:11]}, 1'b1)
    `CHK_EQ(viol, 8'h00)
    // A frozen host keeps the open row and still finishes the read afterwards.
    rd_q.delete();
    do_cmd('{4'h0, 9'h006, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'h0}, 1'b0);
    repeat (2) @(negedge sys_clk_in);
    ce_in = 1'b0;
    repeat (20) @(negedge sys_clk_in);
    `CHK_EQ({row_strobe_n_out, column_strobe_n_out, rd_valid_out}, 3'h0)
    ce_in = 1'b1;
    wait_idle();
    check_rd(4'hC);
    do_cmd('{4'h0, 9'h006, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'h0}, 1'b0);
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b0;
    #1;
    `CHK_EQ({row_strobe_n_out, column_strobe_n_out, cmd_ready_out, data_oe_out}, 4'hC)
    @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    rd_q.delete();
    do_cmd('{4'h0, 9'h006, 9'h007, 4'h0, 4'h0, 1'b0, 1'b1, 4'h0}, 1'b0);
    wait_idle();
    check_rd(4'hC);
    stop_test();
  end

  initial
  begin
    #(25.0 * 12000);
    bad_count++;
    stop_test();
  end
endmodule : test_vdh_host
